// >>> rtl/adcctl_pkg.sv
// Constants shared by the converter control block
package adcctl_pkg;
   // Register offsets (byte addresses, one word each)
   localparam logic [3:0] ADDR_CONTROL_ZERO = 4'h0;
   localparam logic [3:0] ADDR_CONTROL_ONE = 4'h4;
   localparam logic [3:0] ADDR_RESULT_HIGH = 4'h8;
   localparam logic [3:0] ADDR_RESULT_LOW = 4'hc;
   // Control zero fields
   localparam int CZ_POWER_BIT = 0;
   localparam int CZ_GO_BIT = 2;
   localparam int CZ_CHAN_LSB = 3;
   localparam int CZ_CLKSEL_LSB = 6;
   // Control one fields
   localparam int CO_PCFG_LSB = 0;
   localparam int CO_CLKSEL_HIGH_BIT = 6;
   localparam int CO_FORMAT_BIT = 7;
   // Writable masks; unimplemented bits read zero
   localparam logic [7:0] CZ_WRITE_MASK = 8'hf9;
   localparam logic [7:0] CO_WRITE_MASK = 8'hcf;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   // Conversion length in conversion clock periods
   localparam logic [3:0] CONV_PERIODS = 4'hc;
   localparam int RESULT_BITS = 10;
   // Clock divider codes, high bit first
   localparam logic [6:0] DIV_2 = 7'h02;
   localparam logic [6:0] DIV_4 = 7'h04;
   localparam logic [6:0] DIV_8 = 7'h08;
   localparam logic [6:0] DIV_16 = 7'h10;
   localparam logic [6:0] DIV_32 = 7'h20;
   localparam logic [6:0] DIV_64 = 7'h40;
   // Channels on the small and large variants
   localparam logic [3:0] CHANNELS_SMALL = 4'h5;
   localparam logic [3:0] CHANNELS_LARGE = 4'h8;
   typedef enum logic [1:0] {ADCCT_IDLE, ADCCT_START, ADCCT_CONVERT} adcct_state_t;
endpackage

// >>> rtl/adcct_tick_gen.sv
// Conversion clock tick generator: oscillator divider or internal RC edges
`timescale 1ns/100ps
`default_nettype none
module adcct_tick_gen (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic [2:0] clk_select_i,
   input wire logic rc_clk_i,
   output logic tick_o
);
   logic [6:0] div_count_reg, div_count_next;
   logic [6:0] divisor;
   logic rc_meta_reg, rc_sync_reg, rc_prev_reg;
   logic tick_reg, tick_next;
   logic use_rc;

   assign use_rc = (clk_select_i[1:0] == 2'b11);

   always_comb begin
      case (clk_select_i)
         3'b000: divisor = adcctl_pkg::DIV_2;
         3'b001: divisor = adcctl_pkg::DIV_8;
         3'b010: divisor = adcctl_pkg::DIV_32;
         3'b100: divisor = adcctl_pkg::DIV_4;
         3'b101: divisor = adcctl_pkg::DIV_16;
         3'b110: divisor = adcctl_pkg::DIV_64;
         default: divisor = adcctl_pkg::DIV_2;
      endcase
   end

   always_comb begin
      div_count_next = div_count_reg;
      tick_next = 1'b0;
      if (!run_i) begin
         div_count_next = 7'h00;
      end else if (use_rc) begin
         div_count_next = 7'h00;
         tick_next = rc_sync_reg & ~rc_prev_reg;
      end else if (div_count_reg >= divisor - 7'h01) begin
         div_count_next = 7'h00;
         tick_next = 1'b1;
      end else begin
         div_count_next = div_count_reg + 7'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_count_reg <= 7'h00;
         tick_reg <= 1'b0;
         rc_meta_reg <= 1'b0;
         rc_sync_reg <= 1'b0;
         rc_prev_reg <= 1'b0;
      end else begin
         div_count_reg <= div_count_next;
         tick_reg <= tick_next;
         rc_meta_reg <= rc_clk_i;
         rc_sync_reg <= rc_meta_reg;
         rc_prev_reg <= rc_sync_reg;
      end
   end

   assign tick_o = tick_reg;
endmodule
`default_nettype wire

// >>> rtl/adcct_top.sv
// Converter control block: registers, clock select and conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module adcct_top #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Converter core
   input wire logic rc_clk_i,
   input wire logic [9:0] conv_data_i,
   output logic power_o,
   output logic [2:0] channel_o,
   output logic [3:0] port_config_o,
   output logic sample_hold_o,
   output logic done_pulse_o
);
   ////////////////////////////////////////////////////////////////////
   // Register state
   // Bus and control registers
   logic [7:0] ctrl_zero_reg;
   logic [7:0] ctrl_zero_next;
   logic [7:0] ctrl_one_reg;
   logic [7:0] ctrl_one_next;
   logic ack_reg;
   logic ack_next;
   logic err_reg;
   logic err_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   // Sequencer
   logic [9:0] result_reg;
   logic [9:0] result_next;
   logic go_reg;
   logic go_next;
   adcctl_pkg::adcct_state_t state_reg;
   adcctl_pkg::adcct_state_t state_next;
   logic [3:0] period_reg;
   logic [3:0] period_next;
   logic done_reg;
   logic done_next;
   logic hold_reg;
   logic hold_next;
   // Output stages and result word synchronizer
   logic power_out_reg;
   logic power_out_next;
   logic [2:0] chan_out_reg;
   logic [2:0] chan_out_next;
   logic [3:0] pcfg_out_reg;
   logic [3:0] pcfg_out_next;
   logic [9:0] conv_meta_reg;
   logic [9:0] conv_sync_reg;
   // Decode helpers
   logic tick;
   logic bus_req;
   logic write_lane0;
   logic write_zero;
   logic write_one;
   logic addr_ok;
   logic start_req;
   logic chan_legal;
   logic power_on;
   logic fmt_right;
   logic [2:0] clk_select;
   logic [7:0] res_high;
   logic [7:0] res_low;
   logic [7:0] read_byte;
   logic [3:0] chan_limit;
   logic [2:0] chan_field;

   ////////////////////////////////////////////////////////////////////
   // Decode
   assign power_on = ctrl_zero_reg[adcctl_pkg::CZ_POWER_BIT];
   assign fmt_right = ctrl_one_reg[adcctl_pkg::CO_FORMAT_BIT];
   assign clk_select = {ctrl_one_reg[adcctl_pkg::CO_CLKSEL_HIGH_BIT],
                        ctrl_zero_reg[adcctl_pkg::CZ_CLKSEL_LSB +: 2]};
   assign chan_field = ctrl_zero_reg[adcctl_pkg::CZ_CHAN_LSB +: 3];
   assign chan_limit = LARGE_VARIANT ? adcctl_pkg::CHANNELS_LARGE
                                     : adcctl_pkg::CHANNELS_SMALL;
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
   assign write_lane0 = bus_req & wb_we_i & wb_sel_i[0];
   assign addr_ok = (wb_adr_i == adcctl_pkg::ADDR_CONTROL_ZERO) ||
                    (wb_adr_i == adcctl_pkg::ADDR_CONTROL_ONE) ||
                    (wb_adr_i == adcctl_pkg::ADDR_RESULT_HIGH) ||
                    (wb_adr_i == adcctl_pkg::ADDR_RESULT_LOW);
   assign write_zero = write_lane0 && (wb_adr_i == adcctl_pkg::ADDR_CONTROL_ZERO);
   assign write_one = write_lane0 && (wb_adr_i == adcctl_pkg::ADDR_CONTROL_ONE);
   // Power must already be on; a same-write power-up does not start
   assign start_req = write_zero && wb_dat_i[adcctl_pkg::CZ_GO_BIT] &&
                      wb_dat_i[adcctl_pkg::CZ_POWER_BIT] && power_on;
   // Reserved channel codes fall back to channel 0
   assign chan_legal = ({1'b0, chan_field} < chan_limit);

   ////////////////////////////////////////////////////////////////////
   // Result justification and read data
   always_comb begin
      if (fmt_right) begin
         res_high = {6'h00, result_reg[9:8]};
         res_low = result_reg[7:0];
      end else begin
         res_high = result_reg[9:2];
         res_low = {result_reg[1:0], 6'h00};
      end
   end

   always_comb begin
      case (wb_adr_i)
         adcctl_pkg::ADDR_CONTROL_ZERO:
            read_byte = {ctrl_zero_reg[7:3], go_reg, 1'b0, ctrl_zero_reg[0]};
         adcctl_pkg::ADDR_CONTROL_ONE: read_byte = ctrl_one_reg & adcctl_pkg::CO_WRITE_MASK;
         adcctl_pkg::ADDR_RESULT_HIGH: read_byte = res_high;
         adcctl_pkg::ADDR_RESULT_LOW: read_byte = res_low;
         default: read_byte = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Conversion tick source
   adcct_tick_gen u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(state_reg != adcctl_pkg::ADCCT_IDLE),
      .clk_select_i(clk_select),
      .rc_clk_i(rc_clk_i),
      .tick_o(tick)
   );

   ////////////////////////////////////////////////////////////////////
   // Control registers and bus answers
   always_comb begin
      ctrl_zero_next = ctrl_zero_reg;
      ctrl_one_next = ctrl_one_reg;
      ack_next = 1'b0;
      err_next = 1'b0;
      rdata_next = rdata_reg;
      if (bus_req) begin
         // Unmapped offsets answer with an error and write nothing
         if (!addr_ok) begin
            err_next = 1'b1;
         end else begin
            ack_next = 1'b1;
         end
         // Last read value stands on the bus until the next read of a mapped offset
         if (addr_ok && !wb_we_i) begin
            rdata_next = {24'h000000, read_byte};
         end
      end
      if (write_zero) begin
         ctrl_zero_next = wb_dat_i[7:0] & adcctl_pkg::CZ_WRITE_MASK;
      end
      if (write_one) begin
         ctrl_one_next = wb_dat_i[7:0] & adcctl_pkg::CO_WRITE_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Conversion sequencer
   always_comb begin
      state_next = state_reg;
      period_next = period_reg;
      go_next = go_reg;
      result_next = result_reg;
      done_next = 1'b0;
      hold_next = hold_reg;
      case (state_reg)
         adcctl_pkg::ADCCT_IDLE: begin
            if (start_req) begin
               go_next = 1'b1;
               hold_next = 1'b1;
               period_next = 4'h0;
               state_next = adcctl_pkg::ADCCT_CONVERT;
            end
         end
         adcctl_pkg::ADCCT_CONVERT: begin
            // Power cleared mid-conversion aborts: no result, no done
            if (!power_on) begin
               go_next = 1'b0;
               hold_next = 1'b0;
               state_next = adcctl_pkg::ADCCT_IDLE;
            end else if (tick) begin
               if (period_reg == adcctl_pkg::CONV_PERIODS - 4'h1) begin
                  result_next = conv_sync_reg;
                  go_next = 1'b0;
                  done_next = 1'b1;
                  hold_next = 1'b0;
                  state_next = adcctl_pkg::ADCCT_IDLE;
               end else begin
                  period_next = period_reg + 4'h1;
               end
            end
         end
         default: state_next = adcctl_pkg::ADCCT_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_zero_reg <= adcctl_pkg::CONTROL_RESET;
         ctrl_one_reg <= adcctl_pkg::CONTROL_RESET;
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else begin
         ctrl_zero_reg <= ctrl_zero_next;
         ctrl_one_reg <= ctrl_one_next;
         ack_reg <= ack_next;
         err_reg <= err_next;
         rdata_reg <= rdata_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         go_reg <= 1'b0;
         state_reg <= adcctl_pkg::ADCCT_IDLE;
         period_reg <= 4'h0;
         done_reg <= 1'b0;
         hold_reg <= 1'b0;
         result_reg <= 10'h000;
      end else begin
         go_reg <= go_next;
         state_reg <= state_next;
         period_reg <= period_next;
         done_reg <= done_next;
         hold_reg <= hold_next;
         result_reg <= result_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Result word from the analog side; quiet while the hold stands
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conv_meta_reg <= 10'h000;
         conv_sync_reg <= 10'h000;
      end else begin
         conv_meta_reg <= conv_data_i;
         conv_sync_reg <= conv_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Core-facing outputs, registered
   always_comb begin
      power_out_next = power_on;
      chan_out_next = 3'h0;
      if (chan_legal) begin
         chan_out_next = chan_field;
      end
      pcfg_out_next = ctrl_one_reg[adcctl_pkg::CO_PCFG_LSB +: 4];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         power_out_reg <= 1'b0;
         chan_out_reg <= 3'h0;
         pcfg_out_reg <= 4'h0;
      end else begin
         power_out_reg <= power_out_next;
         chan_out_reg <= chan_out_next;
         pcfg_out_reg <= pcfg_out_next;
      end
   end

   assign wb_dat_o = rdata_reg;
   assign wb_ack_o = ack_reg;
   assign wb_err_o = err_reg;
   assign power_o = power_out_reg;
   assign channel_o = chan_out_reg;
   assign port_config_o = pcfg_out_reg;
   assign sample_hold_o = hold_reg;
   assign done_pulse_o = done_reg;
endmodule
`default_nettype wire

// >>> verification/adcct_top_properties.sv
// Port assertions for the converter control block
`timescale 1ns/100ps
`default_nettype none
module adcct_top_properties #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic power_o,
   input wire logic [2:0] channel_o,
   input wire logic sample_hold_o,
   input wire logic done_pulse_o
);
   logic [9:0] busy_reg, busy_next;
   logic held_reg;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////
   // Cycles spent converting so far
   always_comb begin
      busy_next = busy_reg;
      if (sample_hold_o) busy_next = held_reg ? busy_reg + 10'h001 : 10'h001;
   end
   always_ff @(posedge clk_i) begin
      busy_reg <= rst_i ? 10'h000 : busy_next;
      held_reg <= rst_i ? 1'b0 : sample_hold_o;
   end
   ////////////////////////////////////////////////////////////////////////////
   sequence take_s(bit ok);
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && ((wb_adr_i[1:0] == 2'h0) == ok);
   endsequence
   sequence settle_s;
      !done_pulse_o && !sample_hold_o;
   endsequence
   bus_ack_a: assert property (take_s(1'b1) |=> wb_ack_o && !wb_err_o)
      else $error("mapped access not acknowledged next cycle");
   bus_err_a: assert property (take_s(1'b0) |=> wb_err_o && !wb_ack_o)
      else $error("unmapped access not refused next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   done_end_a: assert property (done_pulse_o |-> $past(sample_hold_o) ##1 settle_s)
      else $error("done pulse not closing a conversion");
   conv_length_a: assert property (done_pulse_o |-> busy_reg >= 10'h016 && busy_reg <= 10'h320)
      else $error("conversion length out of range");
   power_gate_a: assert property (!power_o && !$past(power_o) |-> !sample_hold_o)
      else $error("converting while unpowered");
   start_power_a: assert property ($rose(sample_hold_o) |-> power_o)
      else $error("conversion started without power");
   chan_range_a: assert property (LARGE_VARIANT || channel_o < 3'h5)
      else $error("reserved channel routed");
   reset_clear_a: assert property ($fell(rst_i) |-> !power_o && !sample_hold_o && channel_o == 3'h0)
      else $error("outputs not cleared by reset");
endmodule
bind adcct_top adcct_top_properties #(.LARGE_VARIANT(LARGE_VARIANT)) u_props (.clk_i(clk_i),
   .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .power_o(power_o),
   .channel_o(channel_o), .sample_hold_o(sample_hold_o), .done_pulse_o(done_pulse_o));
`default_nettype wire

// >>> verification/adcct_core_model.sv
// Analog core stand-in: per-channel result and gated RC oscillator
`timescale 1ns/100ps
`default_nettype none
module adcct_core_model (
   input wire logic clk_i,
   input wire logic power_i,
   input wire logic [2:0] channel_i,
   input wire logic sample_hold_i,
   output logic [9:0] conv_data_o,
   output logic rc_clk_o
);
   initial rc_clk_o = 1'b0;
   initial conv_data_o = 10'h155;
   // RC source stands still while unpowered
   always #85 rc_clk_o = power_i ? ~rc_clk_o : 1'b0;
   // Data outside a conversion flips every cycle
   always @(posedge clk_i) begin
      if (power_i && sample_hold_i) conv_data_o <= 10'h2a5 ^ {channel_i, 7'h00};
      else conv_data_o <= ~conv_data_o;
   end
endmodule
`default_nettype wire

// >>> verification/test_adcct_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module test_adcct_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, wb_dat_o;
   logic err, wb_ack_o, wb_err_o, power_o, sample_hold_o, done_pulse_o, rc_clk;
   logic [2:0] channel_o;
   logic [3:0] port_config_o;
   logic [9:0] conv_data;
   int miscompares = 0;
   int check_count = 0;
   int dones = 0;
   int divs [8] = '{2, 8, 32, 0, 4, 16, 64, 0};
   adcct_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .wb_err_o(wb_err_o), .rc_clk_i(rc_clk), .conv_data_i(conv_data), .power_o(power_o),
      .channel_o(channel_o), .port_config_o(port_config_o), .sample_hold_o(sample_hold_o),
      .done_pulse_o(done_pulse_o));
   adcct_core_model core (.clk_i(clk_i), .power_i(power_o), .channel_i(channel_o),
      .sample_hold_i(sample_hold_o), .conv_data_o(conv_data), .rc_clk_o(rc_clk));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (done_pulse_o === 1'b1) dones++;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
      rdat = wb_dat_o;
      err = wb_err_o;
      cyc <= 1'b0;
      if (n >= 20) check(32'h1, 32'h0);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      check(rdat, {24'h0, e});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_fields();
      rd(4'h0, 8'h00);
      rd(4'h4, 8'h00);
      rd(4'hc, 8'h00);
      xfer(1'b1, 4'h6, 8'hff);
      check({31'h0, err}, 32'h1);
      xfer(1'b1, 4'h4, 8'hff);
      rd(4'h4, 8'hcf);
      check({28'h0, port_config_o}, 32'hf);
      xfer(1'b1, 4'h0, 8'h06);
      rd(4'h0, 8'h00);
      xfer(1'b1, 4'h0, 8'h05);
      rd(4'h0, 8'h01);
      check({31'h0, sample_hold_o}, 32'h0);
   endtask
   task automatic t_conv(input logic [2:0] code, input logic [2:0] ch, input logic fmt, input int div);
      int n;
      logic [9:0] d;
      logic [7:0] c0;
      d = 10'h2a5 ^ {ch, 7'h00};
      c0 = {code[1:0], ch, 3'h1};
      xfer(1'b1, 4'h4, {fmt, code[2], 6'h00});
      xfer(1'b1, 4'h0, c0);
      xfer(1'b1, 4'h0, c0 | 8'h04);
      rd(4'h0, c0 | 8'h04);
      check({29'h0, channel_o}, {29'h0, ch});
      check({31'h0, power_o}, 32'h1);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (done_pulse_o !== 1'b1 && n < 1000);
      if (div > 0) check({31'h0, n >= 12 * div - 6 && n <= 12 * div + 4}, 32'h1);
      else check({31'h0, n >= 30 && n <= 60}, 32'h1);
      rd(4'h0, c0);
      rd(4'h8, fmt ? {6'h00, d[9:8]} : d[9:2]);
      rd(4'hc, fmt ? d[7:0] : {d[1:0], 6'h00});
      repeat (div > 0 ? 2 * div : 8) @(posedge clk_i);
   endtask
   task automatic t_abort();
      int k;
      k = dones;
      xfer(1'b1, 4'h4, 8'h40);
      xfer(1'b1, 4'h0, 8'h99);
      xfer(1'b1, 4'h0, 8'h9d);
      repeat (100) @(posedge clk_i);
      xfer(1'b1, 4'h0, 8'h98);
      repeat (800) @(posedge clk_i);
      check({31'h0, sample_hold_o | power_o}, 32'h0);
      check(dones, k);
      rd(4'h0, 8'h98);
      xfer(1'b1, 4'h0, 8'h99);
      xfer(1'b1, 4'h0, 8'h9d);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      check({31'h0, sample_hold_o | power_o}, 32'h0);
      rd(4'h0, 8'h00);
      rd(4'h4, 8'h00);
      rd(4'h8, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (miscompares == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_fields();
      for (int i = 0; i < 8; i++) t_conv(i[2:0], 3'(7 - i), i[0], divs[i]);
      t_abort();
      print_verdict();
   end
   initial begin
      #2000000;
      miscompares++;
      print_verdict();
   end
endmodule
`default_nettype wire
